// ### cpi_irq_sink.sv
// Purpose: interrupt controller side, counts node pulses
// Assumes: node lines are one-cycle pulses on mclk
// Notes:   one count per high cycle
`timescale 1ns/1ps
`default_nettype none
module cpi_irq_sink (
	input  wire logic            mclk,
	input  wire logic            rst,
	input  wire logic [3:0]      node_irq,
	output logic      [3:0][7:0] irq_count
);
	logic [3:0][7:0] next_irq_count;
	// count each sampled pulse per node
	always_comb begin
		for (int n = 0; n < 4; n++) begin
			next_irq_count[n] = irq_count[n] + {7'h00, node_irq[n]};
		end
	end
	always_ff @(posedge mclk) begin
		irq_count <= rst ? '0 : next_irq_count;
	end
endmodule
`default_nettype wire

// ### cpi_pin_if.sv
// Purpose: carries pin select fields and selected module inputs between main and pin logic
// Assumes: all signals on mclk
// Notes:   ctrl side drives the selects, pins side returns synchronised choices
`timescale 1ns/1ps
`default_nettype none
interface cpi_pin_if;
	logic [7:0] sel_lo;      // trap and hall selects
	logic [7:0] sel_hi;      // capture selects
	logic [7:0] sel_run;     // timer run selects
	logic       trap_input;
	logic [2:0] hall_position_input;
	logic [1:0] capture_input;
	logic       timer_a_run_input;
	logic       timer_b_run_input;
	modport ctrl (output sel_lo, output sel_hi, output sel_run,
		input trap_input, input hall_position_input, input capture_input,
		input timer_a_run_input, input timer_b_run_input);
	modport pins (input sel_lo, input sel_hi, input sel_run,
		output trap_input, output hall_position_input, output capture_input,
		output timer_a_run_input, output timer_b_run_input);
endinterface
`default_nettype wire

// ### cpi_pin_mux.sv
// Purpose: synchronises pin inputs, applies input selects and port direction control
// Assumes: pins are asynchronous; module_out comes from mclk logic
// Notes:   reserved select codes give a low level
`timescale 1ns/1ps
`default_nettype none
module cpi_pin_mux
	import cpi_pkg::*;
#(
	parameter int NPORT = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	cpi_pin_if.pins               pif,
	input  wire logic [2:0]       trap_pins,
	input  wire logic [5:0]       hall_pins,
	input  wire logic [3:0]       capture_pins,
	input  wire logic [2:0]       run_a_pins,
	input  wire logic [2:0]       run_b_pins,
	input  wire logic [NPORT-1:0] port_direction,
	input  wire logic [NPORT-1:0] port_alt_select_lo,
	input  wire logic [NPORT-1:0] port_alt_select_hi,
	input  wire logic [NPORT-1:0] module_out,
	input  wire logic [NPORT-1:0] pad_in,
	output logic      [NPORT-1:0] pad_out,
	output logic      [NPORT-1:0] pad_oe,
	output logic      [NPORT-1:0] module_in
);
	localparam int W = 19 + NPORT;
	logic [W-1:0] sync1, sync2;
	logic [2:0]   tp;
	logic [5:0]   hp;
	logic [3:0]   cp;
	logic [2:0]   ra, rb;
	logic [NPORT-1:0] pi;
	logic       next_trap, next_run_a, next_run_b;
	logic [2:0] next_hall;
	logic [1:0] next_cap;
	logic [NPORT-1:0] next_pad_out, next_pad_oe, next_module_in;

	assign {pi, rb, ra, cp, hp, tp} = sync2;

	// picks one of three pins by code, reserved code gives 0
	function automatic logic pick3(input logic [2:0] p, input logic [1:0] s);
		logic r;
		r = 1'b0;
		if (s < 2'h3) begin
			r = p[s];
		end
		return r;
	endfunction

	// picks one of two pins by code, reserved codes give 0
	function automatic logic pick2(input logic [1:0] p, input logic [1:0] s);
		logic r;
		r = 1'b0;
		if (!s[1]) begin
			r = p[s[0]];
		end
		return r;
	endfunction

	// input selection and port control
	always_comb begin
		next_trap  = pick3(tp, pif.sel_lo[SEL_TRAP_POS +: 2]);
		next_hall  = {pick2(hp[5:4], pif.sel_lo[SEL_HALL2_POS +: 2]),
			pick2(hp[3:2], pif.sel_lo[SEL_HALL1_POS +: 2]),
			pick2(hp[1:0], pif.sel_lo[SEL_HALL0_POS +: 2])};
		next_cap   = {pick2(cp[3:2], pif.sel_hi[SEL_CAP2_POS +: 2]),
			pick2(cp[1:0], pif.sel_hi[SEL_CAP1_POS +: 2])};
		next_run_a = pick3(ra, pif.sel_run[SEL_RUNA_POS +: 2]);
		next_run_b = pick3(rb, pif.sel_run[SEL_RUNB_POS +: 2]);
		for (int i = 0; i < NPORT; i++) begin
			next_pad_oe[i]    = port_direction[i] &&
				({port_alt_select_hi[i], port_alt_select_lo[i]} == ALT_MODULE);
			next_pad_out[i]   = next_pad_oe[i] & module_out[i];
			next_module_in[i] = ~port_direction[i] & pi[i];
		end
	end

	// two-stage synchroniser and output registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1                   <= '0;
			sync2                   <= '0;
			pif.trap_input          <= 1'b0;
			pif.hall_position_input <= 3'h0;
			pif.capture_input       <= 2'h0;
			pif.timer_a_run_input   <= 1'b0;
			pif.timer_b_run_input   <= 1'b0;
			pad_out                 <= '0;
			pad_oe                  <= '0;
			module_in               <= '0;
		end else begin
			sync1                   <= {pad_in, run_b_pins, run_a_pins, capture_pins, hall_pins, trap_pins};
			sync2                   <= sync1;
			pif.trap_input          <= next_trap;
			pif.hall_position_input <= next_hall;
			pif.capture_input       <= next_cap;
			pif.timer_a_run_input   <= next_run_a;
			pif.timer_b_run_input   <= next_run_b;
			pad_out                 <= next_pad_out;
			pad_oe                  <= next_pad_oe;
			module_in               <= next_module_in;
		end
	end
endmodule
`default_nettype wire

// ### cpi_pkg.sv
// Purpose: constants shared by the capture/compare interrupt, pin select and paging glue
// Assumes: special-function-register bus with 8-bit data, one clock (mclk)
// Notes:   offsets are byte addresses in the non-mapped special-function area
//
// Summary of operation
// - A request comes from a hardware event or from software setting the matching status flag.
// - Every event makes a request whether or not its status flag is already set.
// - The status register is read-only and bus writes to it change nothing.
// - Writing ones to the set register sets flags and to the clear register clears them, bit by bit.
// - A request reaches an interrupt line only when its source enable bit is set.
// - Each pair of sources (0/1, 2/3, ...) is steered to one of four interrupt lines by a shared node pointer field.
// - Trap select picks one of three pins (00, 01, 10) and each Hall select one of two (00, 01).
// - Capture selects for channels one and two pick one of two pins, run selects one of three.
// - A port line drives a timer output only with direction 1 and module alternate select; it feeds an input only with direction 0.
// - Registers respond only while the map select is 0, arranged as three pages (0, 2, 3) on shared addresses.
// - The page register at A3 holds page and control and is reachable on every page.
// - Page operation 0X writes the page, 10 saves the old page to a slot while writing, 11 restores from a slot.
// - The three-bit page field writes the new page and reads the active one; the slot field picks one of four slots.
package cpi_pkg;
	//------------------------------------------------------------
	// register addresses and pages
	//------------------------------------------------------------
	localparam logic [7:0] ADDR_PAGE      = 8'hA3;
	localparam logic [7:0] ADDR_9C        = 8'h9C;
	localparam logic [7:0] ADDR_9D        = 8'h9D;
	localparam logic [7:0] ADDR_9E        = 8'h9E;
	localparam logic [7:0] ADDR_9F        = 8'h9F;
	localparam logic [7:0] ADDR_A4        = 8'hA4;
	localparam logic [7:0] ADDR_A5        = 8'hA5;
	localparam logic [2:0] PAGE_0         = 3'h0;
	localparam logic [2:0] PAGE_2         = 3'h2;
	localparam logic [2:0] PAGE_3         = 3'h3;
	//------------------------------------------------------------
	// page register fields
	//------------------------------------------------------------
	localparam int         PG_OPER_POS    = 6;
	localparam int         PG_SLOT_POS    = 4;
	localparam int         PG_PAGE_POS    = 0;
	localparam logic [1:0] OPER_SAVE      = 2'h2;
	localparam logic [1:0] OPER_RESTORE   = 2'h3;
	localparam logic [2:0] PAGE_RESET     = 3'h0;
	//------------------------------------------------------------
	// select field positions and codes
	//------------------------------------------------------------
	localparam int         SEL_TRAP_POS   = 0;
	localparam int         SEL_HALL0_POS  = 2;
	localparam int         SEL_HALL1_POS  = 4;
	localparam int         SEL_HALL2_POS  = 6;
	localparam int         SEL_CAP1_POS   = 0;
	localparam int         SEL_CAP2_POS   = 2;
	localparam int         SEL_RUNA_POS   = 0;
	localparam int         SEL_RUNB_POS   = 2;
	localparam logic [1:0] ALT_MODULE     = 2'h1;  // {hi, lo} picking the module output
	//------------------------------------------------------------
	// reset values
	//------------------------------------------------------------
	localparam logic [15:0] IRQ_RESET     = 16'h0000;
	localparam logic [7:0]  SEL_RESET     = 8'h00;
endpackage

// ### cpi_top.sv
// Purpose: interrupt flags, enables, node steering, paged register window, pin selects
// Assumes: hw_event and module_out come from mclk logic; pins are asynchronous
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module cpi_top
	import cpi_pkg::*;
#(
	parameter int NPORT = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             sfr_map_select,
	input  wire logic [7:0]       sfr_addr,
	input  wire logic [7:0]       sfr_wdata,
	input  wire logic             sfr_wr,
	input  wire logic             sfr_rd,
	output logic      [7:0]       sfr_rdata,
	input  wire logic [15:0]      hw_event,
	output logic      [3:0]       node_irq,
	input  wire logic [2:0]       trap_pins,
	input  wire logic [5:0]       hall_pins,
	input  wire logic [3:0]       capture_pins,
	input  wire logic [2:0]       run_a_pins,
	input  wire logic [2:0]       run_b_pins,
	input  wire logic [NPORT-1:0] port_direction,
	input  wire logic [NPORT-1:0] port_alt_select_lo,
	input  wire logic [NPORT-1:0] port_alt_select_hi,
	input  wire logic [NPORT-1:0] module_out,
	input  wire logic [NPORT-1:0] pad_in,
	output logic      [NPORT-1:0] pad_out,
	output logic      [NPORT-1:0] pad_oe,
	output logic      [NPORT-1:0] module_in,
	output logic                  trap_input,
	output logic      [2:0]       hall_position_input,
	output logic      [1:0]       capture_input,
	output logic                  timer_a_run_input,
	output logic                  timer_b_run_input
);
	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	logic [15:0] irq_status_flags, next_irq_status_flags;
	logic [15:0] irq_source_enable, next_irq_source_enable;
	logic [15:0] irq_node_pointer, next_irq_node_pointer;
	logic [7:0]  sel_lo, next_sel_lo;
	logic [7:0]  sel_hi, next_sel_hi;
	logic [7:0]  sel_run, next_sel_run;
	logic [2:0]  page, next_page;
	logic [2:0]  slot [4];
	logic [2:0]  next_slot [4];
	logic [7:0]  next_rdata;
	logic [3:0]  next_node_irq;
	logic [15:0] set_mask, clr_mask, req, fwd;
	logic        acc, pg_wr;
	logic [1:0]  page_operation;
	logic [1:0]  pg_slot;

	cpi_pin_if pif ();

	//------------------------------------------------------------
	// bus decode
	//------------------------------------------------------------
	// accesses reach the block only in the standard map
	assign acc     = ~sfr_map_select;
	assign pg_wr   = acc & sfr_wr & (sfr_addr == ADDR_PAGE);
	assign page_operation = sfr_wdata[PG_OPER_POS +: 2];
	assign pg_slot = sfr_wdata[PG_SLOT_POS +: 2];

	// write strobes of the set and clear registers
	always_comb begin
		set_mask = 16'h0000;
		clr_mask = 16'h0000;
		if (acc & sfr_wr & (page == PAGE_2) & (sfr_addr == ADDR_A4)) begin
			set_mask[7:0] = sfr_wdata;
		end
		if (acc & sfr_wr & (page == PAGE_2) & (sfr_addr == ADDR_A5)) begin
			set_mask[15:8] = sfr_wdata;
		end
		if (acc & sfr_wr & (page == PAGE_0) & (sfr_addr == ADDR_A4)) begin
			clr_mask[7:0] = sfr_wdata;
		end
		if (acc & sfr_wr & (page == PAGE_0) & (sfr_addr == ADDR_A5)) begin
			clr_mask[15:8] = sfr_wdata;
		end
	end

	//------------------------------------------------------------
	// interrupt flags and node steering
	//------------------------------------------------------------
	// requests do not look at the flag state
	always_comb begin
		req = hw_event | set_mask;
		fwd = req & irq_source_enable;
		// set wins over a clear in the same cycle; no bus path writes the flags directly
		next_irq_status_flags = (irq_status_flags & ~clr_mask) | req;
		next_node_irq = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (fwd[i]) begin
				next_node_irq[irq_node_pointer[2*(i/2) +: 2]] = 1'b1;
			end
		end
	end

	//------------------------------------------------------------
	// configuration registers
	//------------------------------------------------------------
	// paged writes to enable, node pointer and selects
	always_comb begin
		next_irq_source_enable = irq_source_enable;
		next_irq_node_pointer  = irq_node_pointer;
		next_sel_lo            = sel_lo;
		next_sel_hi            = sel_hi;
		next_sel_run           = sel_run;
		if (acc & sfr_wr) begin
			case (page)
				PAGE_2: begin
					case (sfr_addr)
						ADDR_9C: next_irq_source_enable[7:0]  = sfr_wdata;
						ADDR_9D: next_irq_source_enable[15:8] = sfr_wdata;
						ADDR_9E: next_irq_node_pointer[7:0]   = sfr_wdata;
						ADDR_9F: next_irq_node_pointer[15:8]  = sfr_wdata;
						default: ;
					endcase
				end
				PAGE_3: begin
					case (sfr_addr)
						ADDR_9E: next_sel_lo  = sfr_wdata;
						ADDR_9F: next_sel_hi  = sfr_wdata;
						ADDR_A4: next_sel_run = sfr_wdata;
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	//------------------------------------------------------------
	// page register
	//------------------------------------------------------------
	// direct write, save-and-write, or restore
	always_comb begin
		next_page = page;
		next_slot = slot;
		if (pg_wr) begin
			case (page_operation)
				OPER_SAVE: begin
					next_slot[pg_slot] = page;
					next_page          = sfr_wdata[PG_PAGE_POS +: 3];
				end
				OPER_RESTORE: next_page = slot[pg_slot];
				default:    next_page = sfr_wdata[PG_PAGE_POS +: 3];
			endcase
		end
	end

	//------------------------------------------------------------
	// read mux
	//------------------------------------------------------------
	// page register visible on every page, others by page
	always_comb begin
		next_rdata = 8'h00;
		if (acc & sfr_rd) begin
			if (sfr_addr == ADDR_PAGE) begin
				next_rdata = {5'h00, page};
			end else begin
				case ({page, sfr_addr})
					{PAGE_2, ADDR_9C}: next_rdata = irq_source_enable[7:0];
					{PAGE_2, ADDR_9D}: next_rdata = irq_source_enable[15:8];
					{PAGE_2, ADDR_9E}: next_rdata = irq_node_pointer[7:0];
					{PAGE_2, ADDR_9F}: next_rdata = irq_node_pointer[15:8];
					{PAGE_3, ADDR_9C}: next_rdata = irq_status_flags[7:0];
					{PAGE_3, ADDR_9D}: next_rdata = irq_status_flags[15:8];
					{PAGE_3, ADDR_9E}: next_rdata = sel_lo;
					{PAGE_3, ADDR_9F}: next_rdata = sel_hi;
					{PAGE_3, ADDR_A4}: next_rdata = sel_run;
					default:           next_rdata = 8'h00;
				endcase
			end
		end
	end

	// register all state
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_status_flags  <= IRQ_RESET;
			irq_source_enable <= IRQ_RESET;
			irq_node_pointer  <= IRQ_RESET;
			sel_lo            <= SEL_RESET;
			sel_hi            <= SEL_RESET;
			sel_run           <= SEL_RESET;
			page              <= PAGE_RESET;
			slot              <= '{default: PAGE_RESET};
			sfr_rdata         <= 8'h00;
			node_irq          <= 4'h0;
		end else begin
			irq_status_flags  <= next_irq_status_flags;
			irq_source_enable <= next_irq_source_enable;
			irq_node_pointer  <= next_irq_node_pointer;
			sel_lo            <= next_sel_lo;
			sel_hi            <= next_sel_hi;
			sel_run           <= next_sel_run;
			page              <= next_page;
			slot              <= next_slot;
			sfr_rdata         <= next_rdata;
			node_irq          <= next_node_irq;
		end
	end

	//------------------------------------------------------------
	// pin logic
	//------------------------------------------------------------
	assign pif.sel_lo              = sel_lo;
	assign pif.sel_hi              = sel_hi;
	assign pif.sel_run             = sel_run;
	assign trap_input              = pif.trap_input;
	assign hall_position_input     = pif.hall_position_input;
	assign capture_input           = pif.capture_input;
	assign timer_a_run_input       = pif.timer_a_run_input;
	assign timer_b_run_input       = pif.timer_b_run_input;

	cpi_pin_mux #(.NPORT(NPORT)) u_pins (
		.mclk               (mclk),
		.rst                (rst),
		.pif                (pif.pins),
		.trap_pins          (trap_pins),
		.hall_pins          (hall_pins),
		.capture_pins       (capture_pins),
		.run_a_pins         (run_a_pins),
		.run_b_pins         (run_b_pins),
		.port_direction     (port_direction),
		.port_alt_select_lo (port_alt_select_lo),
		.port_alt_select_hi (port_alt_select_hi),
		.module_out         (module_out),
		.pad_in             (pad_in),
		.pad_out            (pad_out),
		.pad_oe             (pad_oe),
		.module_in          (module_in)
	);
endmodule
`default_nettype wire

// ### cpi_top_assertions.sv
// Purpose: concurrent checks on the ports of cpi_top
// Assumes: one clock mclk, synchronous active-high rst
// Notes:   bound to cpi_top after the module
`timescale 1ns/1ps
`default_nettype none
module cpi_top_chk
	import cpi_pkg::*;
#(
	parameter int NPORT = 8
) (
	input wire logic             mclk,
	input wire logic             rst,
	input wire logic             sfr_map_select,
	input wire logic [7:0]       sfr_addr,
	input wire logic [7:0]       sfr_wdata,
	input wire logic             sfr_wr,
	input wire logic             sfr_rd,
	input wire logic [7:0]       sfr_rdata,
	input wire logic [15:0]      hw_event,
	input wire logic [3:0]       node_irq,
	input wire logic [NPORT-1:0] port_direction,
	input wire logic [NPORT-1:0] port_alt_select_lo,
	input wire logic [NPORT-1:0] port_alt_select_hi,
	input wire logic [NPORT-1:0] module_out,
	input wire logic [NPORT-1:0] pad_out,
	input wire logic [NPORT-1:0] pad_oe,
	input wire logic [NPORT-1:0] module_in
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	//------------------------------------------------------------
	// helper: page last written in direct mode
	//------------------------------------------------------------
	logic       pg_wr;
	logic [2:0] last_pg;
	logic [2:0] next_last_pg;
	always_comb begin
		pg_wr = sfr_wr && !sfr_map_select && sfr_addr == ADDR_PAGE;
		next_last_pg = (pg_wr && !sfr_wdata[7]) ? sfr_wdata[2:0] : last_pg;
	end
	always_ff @(posedge mclk) begin
		last_pg <= rst ? PAGE_RESET : next_last_pg;
	end
	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	chk_irq_cause: assert property (node_irq != 4'h0 |-> $past(hw_event) != 16'h0000 ||
		($past(sfr_wr) && !$past(sfr_map_select))) else $error("node pulse without a request");
	chk_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_map_hide: assert property ($past(sfr_map_select) && $past(sfr_rd) |-> sfr_rdata == 8'h00)
		else $error("read answered while mapped away");
	chk_page_zero: assert property ($past(sfr_rd) && !$past(sfr_map_select)
		&& $past(sfr_addr) == ADDR_PAGE |-> sfr_rdata[7:3] == 5'h00) else $error("page upper bits not zero");
	chk_page_write: assert property (pg_wr && !sfr_wdata[7] ##1 !sfr_wr ##1
		sfr_rd && !sfr_map_select && sfr_addr == ADDR_PAGE |=> sfr_rdata[2:0] == last_pg)
		else $error("direct page write not read back");
	chk_pad_oe: assert property (!$past(rst) |-> pad_oe == ($past(port_direction)
		& $past(port_alt_select_lo) & ~$past(port_alt_select_hi))) else $error("pad enable wrong");
	chk_pad_out: assert property (!$past(rst) |-> pad_out == ($past(module_out) & pad_oe))
		else $error("pad output wrong");
	chk_in_mask: assert property (!$past(rst) |-> (module_in & $past(port_direction)) == '0)
		else $error("output line fed to module");
	cov_node2: cover property (node_irq[2]);
	cov_page_rd: cover property (sfr_rd && sfr_addr == ADDR_PAGE);
	cov_drive: cover property (pad_oe != '0);
endmodule
bind cpi_top cpi_top_chk #(.NPORT(NPORT)) u_chk (.mclk, .rst, .sfr_map_select, .sfr_addr, .sfr_wdata,
	.sfr_wr, .sfr_rd, .sfr_rdata, .hw_event, .node_irq, .port_direction, .port_alt_select_lo,
	.port_alt_select_hi, .module_out, .pad_out, .pad_oe, .module_in);
`default_nettype wire

// ### tb_cpi_top.sv
// Purpose: register, interrupt, pin select and port checks of cpi_top
// Assumes: inputs change at the falling edge of mclk
// Notes:   pin paths settle in 3 cycles, 4 are waited
`timescale 1ns/1ps
`default_nettype none
module tb_cpi_top
	import cpi_pkg::*;
;
	logic            mclk = 1'b0;
	logic            rst, sfr_map_select, sfr_wr, sfr_rd;
	logic [7:0]      sfr_addr, sfr_wdata, sfr_rdata;
	logic [15:0]     hw_event;
	logic [3:0]      node_irq, capture_pins;
	logic [2:0]      trap_pins, run_a_pins, run_b_pins, hall_position_input;
	logic [5:0]      hall_pins;
	logic [7:0]      port_direction, port_alt_select_lo, port_alt_select_hi, module_out, pad_in;
	logic [7:0]      pad_out, pad_oe, module_in;
	logic            trap_input, timer_a_run_input, timer_b_run_input;
	logic [1:0]      capture_input;
	logic [3:0][7:0] irq_count;
	logic [3:0][7:0] exp_irq = {8'h00, 8'h02, 8'h01, 8'h00};
	int              err_count = 0;
	int              num_checks = 0;
	always #20 mclk = ~mclk;
	cpi_top #(.NPORT(8)) DUT (.mclk, .rst, .sfr_map_select, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
		.sfr_rdata, .hw_event, .node_irq, .trap_pins, .hall_pins, .capture_pins, .run_a_pins, .run_b_pins,
		.port_direction, .port_alt_select_lo, .port_alt_select_hi, .module_out, .pad_in, .pad_out, .pad_oe,
		.module_in, .trap_input, .hall_position_input, .capture_input, .timer_a_run_input, .timer_b_run_input);
	cpi_irq_sink u_sink (.mclk, .rst, .node_irq, .irq_count);
	//------------------------------------------------------------
	// tasks
	//------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge mclk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk);
		sfr_rd = 1'b1;
		sfr_addr = a;
		@(negedge mclk);
		sfr_rd = 1'b0;
		check(sfr_rdata, exp);
	endtask
	task automatic pulse(input logic [15:0] ev);
		@(negedge mclk);
		hw_event = ev;
		@(negedge mclk);
		hw_event = 16'h0000;
	endtask
	task automatic settle();
		repeat (4) @(negedge mclk);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		{rst, sfr_map_select, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, hw_event} = {1'b1, 35'h0};
		{trap_pins, hall_pins, capture_pins, run_a_pins, run_b_pins} = 19'h0;
		{port_direction, port_alt_select_lo, port_alt_select_hi, module_out, pad_in} = 40'h0;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		rd(ADDR_PAGE, 8'h00);
		wr(ADDR_PAGE, 8'h02);
		rd(ADDR_PAGE, 8'h02);
		wr(ADDR_PAGE, 8'h93);
		rd(ADDR_PAGE, 8'h03);
		wr(ADDR_PAGE, 8'hD0);
		rd(ADDR_PAGE, 8'h02);
		wr(ADDR_9C, 8'h09);
		wr(ADDR_9E, 8'h09);
		pulse(16'h0008);
		pulse(16'h0008);
		pulse(16'h0010);
		wr(ADDR_A4, 8'h01);
		wr(ADDR_PAGE, 8'h03);
		rd(ADDR_9C, 8'h19);
		wr(ADDR_9C, 8'h00);
		rd(ADDR_9C, 8'h19);
		wr(ADDR_PAGE, 8'h00);
		wr(ADDR_A4, 8'h09);
		wr(ADDR_PAGE, 8'h03);
		rd(ADDR_9C, 8'h10);
		for (int n = 0; n < 4; n++) check(irq_count[n], exp_irq[n]);
		sfr_map_select = 1'b1;
		wr(ADDR_PAGE, 8'h00);
		rd(ADDR_PAGE, 8'h00);
		sfr_map_select = 1'b0;
		rd(ADDR_PAGE, 8'h03);
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_9E, 8'(c));
			trap_pins = (c < 3) ? 3'(1 << c) : 3'h7;
			settle();
			check(8'(trap_input), (c < 3) ? 8'h01 : 8'h00);
		end
		wr(ADDR_9E, 8'h10);
		wr(ADDR_9F, 8'h01);
		wr(ADDR_A4, 8'h06);
		{hall_pins, capture_pins, run_a_pins, run_b_pins} = {6'h29, 4'h6, 3'h4, 3'h2};
		settle();
		check(8'(hall_position_input), 8'h03);
		check(8'(capture_input), 8'h03);
		check(8'({timer_b_run_input, timer_a_run_input}), 8'h03);
		{port_direction, port_alt_select_lo, port_alt_select_hi} = {8'h0F, 8'h05, 8'h01};
		{module_out, pad_in} = 16'hFFFF;
		settle();
		check(pad_oe, 8'h04);
		check(pad_out, 8'h04);
		check(module_in, 8'hF0);
		// select read-back, page op 01, high-byte sources, restore of an unused slot
		rd(ADDR_9E, 8'h10);
		rd(ADDR_A4, 8'h06);
		wr(ADDR_PAGE, 8'h62);
		rd(ADDR_PAGE, 8'h02);
		rd(ADDR_9E, 8'h09);
		wr(ADDR_9D, 8'h02);
		wr(ADDR_9F, 8'h03);
		rd(ADDR_9C, 8'h09);
		pulse(16'h0200);
		wr(ADDR_A5, 8'h40);
		wr(ADDR_PAGE, 8'hE0);
		rd(ADDR_PAGE, 8'h00);
		wr(ADDR_A5, 8'h02);
		wr(ADDR_PAGE, 8'h03);
		rd(ADDR_9D, 8'h40);
		exp_irq[3] = 8'h01;
		for (int n = 0; n < 4; n++) check(irq_count[n], exp_irq[n]);
		end_of_test();
	end
endmodule
`default_nettype wire
